// >>> pll_ctrl_cfg.svh
// Bit positions, codes and timing counts of the synthesizer control latches.
// What this block does
// - Control bits 11 load init, 10 function
// - Control bits 00 reference, 01 AB latch
// - Counter reset bit holds R, AB counters
// - Counters released together, staying phase aligned
// - Chip enable low powers down at once
// - First power-down bit alone: immediate power-down
// - Both power-down bits: wait for pump event
// - Power-down holds counters, three-states pump, resets detect
// - Serial register keeps working during power-down
// - Three select bits steer output multiplexer
// - Fastlock only when enable bit set
// - Mode bit picks fastlock mode one/two
// - Mode one: gain bit held until host clears
// - Mode two: timeout clears gain bit itself
// - Timer bits set timeout; runs mode two only
// - Two current fields: setting one, setting two
// - One bit sets phase detector polarity
// - Three-state bit floats or enables pump
// - Init load updates function, pulses reset
// - First AB load after init pulses again
// - Init word with both power-down bits: immediate power-down
`ifndef PLL_CTRL_CFG_SVH
`define PLL_CTRL_CFG_SVH
`define WORD_BITS 24
`define SEL_REF 2'h0
`define SEL_AB 2'h1
`define SEL_FUNC 2'h2
`define SEL_INIT 2'h3
`define POS_CNT_RESET 2
`define POS_PD_REQ 3
`define POS_MUX_LO 4
`define POS_PD_POL 7
`define POS_CP_3STATE 8
`define POS_FL_EN 9
`define POS_FL_MODE 10
`define POS_TIMER_LO 11
`define POS_CUR1_LO 15
`define POS_CUR2_LO 18
`define POS_PD_SYNC 21
`define POS_PRESCALE_LO 22
`define POS_BOOST 21
`define FUNC_RESET 24'h000000
`define TIMEOUT_UNIT 4
`endif

// >>> pll_ctrl_pkg.sv
// Types shared by the synthesizer control-latch logic.
package pll_ctrl_pkg;
  // Power-down sequencing states
  typedef enum logic [1:0] {
    pd_awake = 2'b00,
    pd_pending = 2'b01,
    pd_asleep = 2'b10
  } pd_state_type;
endpackage

// >>> pll_control_latch_logic.sv
// Control-latch logic: serial input register, function/init latches, power-down, fastlock.
`timescale 1ns/10ps
`include "pll_ctrl_cfg.svh"
module pll_control_latch_logic
  import pll_ctrl_pkg::*;
#(
  parameter int TIMER_WIDTH = 8,
  parameter int TIMEOUT_UNIT = `TIMEOUT_UNIT
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic ser_clk,
  input wire logic ser_data,
  input wire logic ser_load,
  input wire logic chip_enable,
  input wire logic cp_event,
  input wire logic pfd_tick,
  output logic counter_hold,
  output logic reset_pulse,
  output logic powered_down,
  output logic pump_tristate,
  output logic clock_detect_reset,
  output logic [2:0] pump_current,
  output logic fastlock_active,
  output logic pump_boost_bit,
  output logic [2:0] outmux_sel,
  output logic pd_polarity,
  output logic [1:0] prescale_sel,
  output logic [`WORD_BITS-1:0] ref_latch_q,
  output logic ref_load,
  output logic [`WORD_BITS-1:0] ab_latch_q,
  output logic ab_load
);

  // Synchronisers for the serial pins and chip enable
  logic sclk_s1_q, sclk_s2_q, sclk_s3_q;
  logic sdat_s1_q, sdat_s2_q;
  logic sld_s1_q, sld_s2_q, sld_s3_q;
  logic ce_s1_q, ce_s2_q;
  logic sclk_rise;  // Rising serial clock edge, one cycle
  logic sld_rise;  // Rising load strobe edge, one cycle
  logic [`WORD_BITS-1:0] shift_q;  // Serial input register
  logic [`WORD_BITS-1:0] func_q;  // Function settings
  logic load_func;  // Function or init word taken this cycle
  logic load_init;  // Init word taken this cycle
  logic load_ab;  // AB word taken this cycle
  logic init_armed_q;  // Next AB load must pulse reset
  logic pulse_q;  // Internal counter reset pulse
  pd_state_type pd_q;  // Programmed power-down state
  logic pd_any;  // Any power-down in force
  logic boost_q;  // Gain bit as held by the device
  logic [TIMER_WIDTH-1:0] timer_q;  // Fastlock mode two countdown
  logic timer_run;  // Timer counts this cycle
  logic timeout_hit;  // Timer expires this cycle

  // Timeout length in PFD ticks for a four-bit timer code
  function automatic logic [TIMER_WIDTH-1:0] timeout_len(input logic [3:0] code);
    timeout_len = TIMER_WIDTH'((int'(code) + 1) * TIMEOUT_UNIT);
  endfunction

  // Two flip-flops per pin, then one more for edge finding
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sclk_s1_q <= 1'b0;
      sclk_s2_q <= 1'b0;
      sclk_s3_q <= 1'b0;
      sdat_s1_q <= 1'b0;
      sdat_s2_q <= 1'b0;
      sld_s1_q <= 1'b0;
      sld_s2_q <= 1'b0;
      sld_s3_q <= 1'b0;
      ce_s1_q <= 1'b0;
      ce_s2_q <= 1'b0;
    end else begin
      sclk_s1_q <= ser_clk;
      sclk_s2_q <= sclk_s1_q;
      sclk_s3_q <= sclk_s2_q;
      sdat_s1_q <= ser_data;
      sdat_s2_q <= sdat_s1_q;
      sld_s1_q <= ser_load;
      sld_s2_q <= sld_s1_q;
      sld_s3_q <= sld_s2_q;
      ce_s1_q <= chip_enable;
      ce_s2_q <= ce_s1_q;
    end
  end

  assign sclk_rise = sclk_s2_q & ~sclk_s3_q;
  assign sld_rise = sld_s2_q & ~sld_s3_q;

  // Shift register, most significant bit first; never gated by power-down
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      shift_q <= '0;
    end else if (sclk_rise) begin
      shift_q <= {shift_q[`WORD_BITS-2:0], sdat_s2_q};
    end
  end

  // Latch decode on the two low control bits
  assign load_func = sld_rise & shift_q[1];
  assign load_init = sld_rise & (shift_q[1:0] == `SEL_INIT);
  assign load_ab = sld_rise & (shift_q[1:0] == `SEL_AB);

  // Function settings: loaded by function and init words alike
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      func_q <= `FUNC_RESET;
    end else if (load_func) begin
      func_q <= shift_q;
    end
  end

  // Reference and AB counter words handed on to the counters
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ref_latch_q <= '0;
      ref_load <= 1'b0;
      ab_latch_q <= '0;
      ab_load <= 1'b0;
    end else begin
      ref_load <= sld_rise & (shift_q[1:0] == `SEL_REF);
      ab_load <= load_ab;
      if (sld_rise && shift_q[1:0] == `SEL_REF) begin
        ref_latch_q <= shift_q;
      end
      if (load_ab) begin
        ab_latch_q <= shift_q;
      end
    end
  end

  // Init arms a second pulse for the first AB load after it
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      init_armed_q <= 1'b0;
    end else if (load_init) begin
      init_armed_q <= 1'b1;
    end else if (load_ab) begin
      init_armed_q <= 1'b0;
    end
  end

  // One-cycle internal reset pulse to the R and AB counters
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pulse_q <= 1'b0;
    end else begin
      pulse_q <= load_init | (load_ab & init_armed_q);
    end
  end

  // Programmed power-down sequencing
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pd_q <= pd_awake;
    end else begin
      case (pd_q)
        pd_awake: begin
          if (load_func && shift_q[`POS_PD_REQ]) begin
            if (!shift_q[`POS_PD_SYNC]) begin
              pd_q <= pd_asleep;
            end else if (load_init) begin
              pd_q <= pd_asleep;
            end else begin
              pd_q <= pd_pending;
            end
          end
        end
        pd_pending: begin
          if (load_func && !shift_q[`POS_PD_REQ]) begin
            pd_q <= pd_awake;
          end else if (load_func && (!shift_q[`POS_PD_SYNC] || load_init)) begin
            // A new asynchronous request or an init word must not wait for the pump
            pd_q <= pd_asleep;
          end else if (cp_event) begin
            pd_q <= pd_asleep;
          end
        end
        pd_asleep: begin
          if (load_func && !shift_q[`POS_PD_REQ]) begin
            pd_q <= pd_awake;
          end
        end
        default: begin
          pd_q <= pd_awake;
        end
      endcase
    end
  end

  // Chip enable overrides the programmed bits
  assign pd_any = ~ce_s2_q | (pd_q == pd_asleep);

  // Status and control outputs, all registered
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      powered_down <= 1'b1;
      counter_hold <= 1'b1;
      pump_tristate <= 1'b1;
      clock_detect_reset <= 1'b1;
      reset_pulse <= 1'b0;
    end else begin
      powered_down <= pd_any;
      // One hold line for R and N counters keeps their release aligned
      counter_hold <= func_q[`POS_CNT_RESET] | pd_any | pulse_q;
      pump_tristate <= func_q[`POS_CP_3STATE] | pd_any | func_q[`POS_CNT_RESET]
        | pulse_q;
      clock_detect_reset <= pd_any;
      reset_pulse <= pulse_q;
    end
  end

  // Plain function settings on to their users
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      outmux_sel <= 3'h0;
      pd_polarity <= 1'b0;
      prescale_sel <= 2'h0;
    end else begin
      outmux_sel <= func_q[`POS_MUX_LO +: 3];
      pd_polarity <= func_q[`POS_PD_POL];
      prescale_sel <= func_q[`POS_PRESCALE_LO +: 2];
    end
  end

  // Timer runs only in fastlock mode two with the gain bit set
  assign timer_run = func_q[`POS_FL_EN] & func_q[`POS_FL_MODE] & boost_q
    & ~pd_any;
  assign timeout_hit = timer_run & pfd_tick & (timer_q == TIMER_WIDTH'(1));

  // Gain bit: set by AB load, cleared by host or by mode two timeout
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      boost_q <= 1'b0;
    end else if (load_ab) begin
      boost_q <= shift_q[`POS_BOOST];
    end else if (timeout_hit) begin
      boost_q <= 1'b0;
    end
  end

  // Timeout counter, held at load state outside a mode two run
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      timer_q <= '0;
    end else if (!timer_run || load_ab) begin
      timer_q <= timeout_len(func_q[`POS_TIMER_LO +: 4]);
    end else if (pfd_tick && timer_q != TIMER_WIDTH'(1)) begin
      timer_q <= timer_q - TIMER_WIDTH'(1);
    end
  end

  // Current setting two while the gain bit stands, else setting one
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pump_current <= 3'h0;
      fastlock_active <= 1'b0;
      pump_boost_bit <= 1'b0;
    end else begin
      pump_current <= boost_q ? func_q[`POS_CUR2_LO +: 3]
                              : func_q[`POS_CUR1_LO +: 3];
      fastlock_active <= func_q[`POS_FL_EN] & boost_q;
      pump_boost_bit <= boost_q;
    end
  end

  // Assertions
  sequence init_word_s;
    sld_rise && shift_q[1:0] == `SEL_INIT;
  endsequence

  sequence pulse_out_s;
    ##2 reset_pulse;
  endsequence

  init_pulse_a: assert property (@(posedge clock) disable iff (!rstn)
    init_word_s |-> pulse_out_s)
    else $error("init load gave no reset pulse");

  ab_repulse_a: assert property (@(posedge clock) disable iff (!rstn)
    load_ab && init_armed_q |=> pulse_q ##1 !init_armed_q)
    else $error("first AB load after init gave no pulse");

  ab_nopulse_a: assert property (@(posedge clock) disable iff (!rstn)
    load_ab && !init_armed_q && !load_init |=> !pulse_q)
    else $error("later AB load pulsed reset");

  ce_down_a: assert property (@(posedge clock) disable iff (!rstn)
    !ce_s2_q |=> powered_down && pump_tristate && counter_hold)
    else $error("chip enable low did not power down");

  async_pd_a: assert property (@(posedge clock) disable iff (!rstn)
    load_func && shift_q[`POS_PD_REQ] && !shift_q[`POS_PD_SYNC] |=> ##1 powered_down)
    else $error("asynchronous power-down late");

  sync_wait_a: assert property (@(posedge clock) disable iff (!rstn)
    pd_q == pd_pending && !cp_event && ce_s2_q && !load_func |=> pd_q == pd_pending)
    else $error("synchronous power-down left without pump event");

  hold_bit_a: assert property (@(posedge clock) disable iff (!rstn)
    func_q[`POS_CNT_RESET] |=> counter_hold)
    else $error("counter reset bit did not hold counters");

  tristate_a: assert property (@(posedge clock) disable iff (!rstn)
    $rose(func_q[`POS_CP_3STATE]) |=> pump_tristate)
    else $error("three-state bit ignored");

  mode1_keep_a: assert property (@(posedge clock) disable iff (!rstn)
    boost_q && !func_q[`POS_FL_MODE] && !load_ab |=> boost_q)
    else $error("mode one gain bit cleared without host");

  timeout_clr_a: assert property (@(posedge clock) disable iff (!rstn)
    timeout_hit && !load_ab |=> !boost_q ##1 pump_current == func_q[`POS_CUR1_LO +: 3])
    else $error("timeout did not restore setting one");

  timer_idle_a: assert property (@(posedge clock) disable iff (!rstn)
    !func_q[`POS_FL_MODE] |=> timer_q == timeout_len($past(func_q[`POS_TIMER_LO +: 4])))
    else $error("timer ran outside mode two");

  mux_sel_a: assert property (@(posedge clock) disable iff (!rstn)
    load_func |=> ##1 outmux_sel == $past(shift_q[`POS_MUX_LO +: 3], 2))
    else $error("mux select not taken from word");

  shift_pd_a: assert property (@(posedge clock) disable iff (!rstn)
    sclk_rise && pd_any |=> shift_q == {$past(shift_q[`WORD_BITS-2:0]), $past(sdat_s2_q)})
    else $error("serial register stalled during power-down");

  pd_effects_a: assert property (@(posedge clock) disable iff (!rstn)
    pd_any |=> counter_hold && pump_tristate && clock_detect_reset)
    else $error("power-down did not hold counters and pump");

  cur_one_a: assert property (@(posedge clock) disable iff (!rstn)
    !boost_q |=> pump_current == $past(func_q[`POS_CUR1_LO +: 3]))
    else $error("setting one not used without gain bit");

  fl_off_a: assert property (@(posedge clock) disable iff (!rstn)
    !func_q[`POS_FL_EN] |=> !fastlock_active
      && timer_q == timeout_len($past(func_q[`POS_TIMER_LO +: 4])))
    else $error("fastlock active while disabled");

  polarity_a: assert property (@(posedge clock) disable iff (!rstn)
    $changed(func_q[`POS_PD_POL]) |=> pd_polarity == $past(func_q[`POS_PD_POL]))
    else $error("phase detector polarity not taken");

  timer_step_a: assert property (@(posedge clock) disable iff (!rstn)
    timer_run && pfd_tick && timer_q != TIMER_WIDTH'(1) && !load_ab
      |=> timer_q == $past(timer_q) - TIMER_WIDTH'(1))
    else $error("timer did not count the tick");

  ref_word_a: assert property (@(posedge clock) disable iff (!rstn)
    sld_rise && shift_q[1:0] == `SEL_REF |=> ref_load && ref_latch_q == $past(shift_q))
    else $error("reference word not handed on");

endmodule

// >>> pll_host_model.sv
// Host controller model that drives the three-wire serial load pins.
`timescale 1ns/10ps
module pll_host_model (
  input wire logic clock,
  output logic ser_clk,
  output logic ser_data,
  output logic ser_load
);
  // Serial clock stands low between frames
  initial begin
    ser_clk = 1'b0;
    ser_data = 1'b0;
    ser_load = 1'b0;
  end
  // Hold the pins for n system clocks, then step just past the edge
  task automatic hold(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  // Shift a whole word MSB first, so the control bits arrive last
  task automatic send_word(input logic [23:0] w);
    for (int i = 23; i >= 0; i--) begin
      ser_data = w[i];
      hold(4);
      ser_clk = 1'b1;
      hold(4);
      ser_clk = 1'b0;
    end
    // Data line no longer shows the last bit once the frame is done
    ser_data = ~w[0];
    hold(4);
    // Strobe transfers the word to the latch picked by bits 1:0
    ser_load = 1'b1;
    hold(4);
    ser_load = 1'b0;
    hold(2);
  endtask
endmodule

// >>> tb_top.sv
// Self-checking bench for the synthesizer control-latch logic.
`timescale 1ns/10ps
module tb_top;
  logic clock, ser_clk, ser_data, ser_load;
  logic rstn = 1'b0, chip_enable = 1'b1, cp_event = 1'b0, pfd_tick = 1'b0;
  logic counter_hold, reset_pulse, powered_down, pump_tristate, clock_detect_reset;
  logic fastlock_active, pump_boost_bit, pd_polarity, ref_load, ab_load;
  logic [2:0] pump_current, outmux_sel;
  logic [1:0] prescale_sel;
  logic [23:0] ref_latch_q, ab_latch_q, w;
  logic [23:0] fw = 24'h000000;
  logic [23:0] ref_q[$], ab_q[$];  // Counter words still owed to the latch strobes
  int errors = 0, samples_checked = 0, pulses = 0;
  bit boost = 1'b0, pd = 1'b1;
  // Short timeout unit keeps the fastlock runs brief
  pll_control_latch_logic #(.TIMEOUT_UNIT(1)) dut_u (
    .clock(clock), .rstn(rstn), .ser_clk(ser_clk), .ser_data(ser_data),
    .ser_load(ser_load), .chip_enable(chip_enable), .cp_event(cp_event),
    .pfd_tick(pfd_tick), .counter_hold(counter_hold), .reset_pulse(reset_pulse),
    .powered_down(powered_down), .pump_tristate(pump_tristate),
    .clock_detect_reset(clock_detect_reset), .pump_current(pump_current),
    .fastlock_active(fastlock_active), .pump_boost_bit(pump_boost_bit),
    .outmux_sel(outmux_sel), .pd_polarity(pd_polarity), .prescale_sel(prescale_sel),
    .ref_latch_q(ref_latch_q), .ref_load(ref_load), .ab_latch_q(ab_latch_q),
    .ab_load(ab_load)
  );
  // Host on the far side of the serial pins
  pll_host_model host_u (
    .clock(clock), .ser_clk(ser_clk), .ser_data(ser_data), .ser_load(ser_load)
  );
  // 50 MHz system clock
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  // Count internal reset pulses as they occur
  always @(posedge clock) begin
    if (reset_pulse === 1'b1) pulses++;
  end
  // Each latch strobe must hand on the oldest word queued for it
  always @(posedge clock) begin
    if (ref_load === 1'b1) begin
      if (ref_q.size() > 0) chk(ref_latch_q, ref_q.pop_front());
      else chk(24'(ref_load), 24'h000000);
    end
    if (ab_load === 1'b1) begin
      if (ab_q.size() > 0) chk(ab_latch_q, ab_q.pop_front());
      else chk(24'(ab_load), 24'h000000);
    end
  end
  // Compare one value and report a mismatch
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Print the verdict and stop
  task automatic complete_run();
    if (errors == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Wait n clocks, landing just after the edge
  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  // One timer time-base tick
  task automatic tick();
    pfd_tick = 1'b1;
    step(1);
    pfd_tick = 1'b0;
    step(2);
  endtask
  // Send a word and update the model's latches
  task automatic load(input logic [23:0] v);
    if (v[1:0] == 2'h0) ref_q.push_back(v);
    if (v[1:0] == 2'h1) ab_q.push_back(v);
    host_u.send_word(v);
    step(6);
    if (v[1]) fw = v;
    if (v[1:0] == 2'h1) boost = v[21];
  endtask
  // Random function word with no power-down and no counter reset
  task automatic rand_func(input logic [1:0] fl);
    w = 24'($urandom);
    w[3:0] = 4'h2;
    w[10:9] = fl;
  endtask
  // Compare the settled function, pump and power-down outputs against the model
  task automatic check_all();
    chk(24'(outmux_sel), 24'(fw[6:4]));
    chk(24'(pd_polarity), 24'(fw[7]));
    chk(24'(prescale_sel), 24'(fw[23:22]));
    // Counter reset three-states the pump as well as holding the counters
    chk(24'(pump_tristate), 24'(fw[8] | fw[2] | pd));
    chk(24'(counter_hold), 24'(fw[2] | pd));
    chk(24'(pump_current), 24'(boost ? fw[20:18] : fw[17:15]));
    chk(24'(pump_boost_bit), 24'(boost));
    chk(24'(fastlock_active), 24'(fw[9] & boost));
    chk(24'(powered_down), 24'(pd));
    chk(24'(clock_detect_reset), 24'(pd));
  endtask
  // Main sequence
  initial begin
    void'($urandom(32'h4aa34878));
    step(2);
    rstn = 1'b1;
    step(5);
    pd = 1'b0;
    check_all();
    repeat (6) begin
      rand_func(2'($urandom));
      load(w);
      check_all();
    end
    load(24'h000006);
    check_all();
    // Chip enable low sleeps at once while shifting goes on
    chip_enable = 1'b0;
    step(5);
    pd = 1'b1;
    check_all();
    w = 24'($urandom);
    w[1:0] = 2'h0;
    load(w);
    chk(ref_latch_q, w);
    chip_enable = 1'b1;
    step(5);
    pd = 1'b0;
    check_all();
    load(24'h00000a);
    pd = 1'b1;
    check_all();
    load(24'h000002);
    pd = 1'b0;
    load(24'h20000a);
    check_all();
    cp_event = 1'b1;
    step(1);
    cp_event = 1'b0;
    step(3);
    pd = 1'b1;
    check_all();
    load(24'h000002);
    pd = 1'b0;
    // Init pulses, then only the first AB load pulses again
    pulses = 0;
    load(24'h000003);
    chk(24'(pulses), 24'h000001);
    load(24'h000001);
    chk(24'(pulses), 24'h000002);
    load(24'h000005);
    chk(24'(pulses), 24'h000002);
    chk(ab_latch_q, 24'h000005);
    load(24'h20000b);
    pd = 1'b1;
    check_all();
    load(24'h000002);
    pd = 1'b0;
    // Mode one keeps the boost regardless of ticks
    rand_func(2'h1);
    load(w);
    load(24'h200001);
    repeat (12) tick();
    check_all();
    load(24'h000001);
    check_all();
    // Mode two clears the boost after (code+1) ticks
    for (int c = 0; c < 4; c++) begin
      rand_func(2'h3);
      w[14:11] = c[3:0];
      load(w);
      load(24'h200001);
      repeat (c) tick();
      check_all();
      tick();
      boost = 1'b0;
      check_all();
    end
    // Every counter word sent must have reached its latch
    chk(24'(ref_q.size()), 24'h000000);
    chk(24'(ab_q.size()), 24'h000000);
    complete_run();
  end
  // Watchdog well past the expected run length
  initial begin
    #500000;
    errors++;
    complete_run();
  end
endmodule
